/* File: shared/gate_select_regs.vh */
// register map and field constants for the gate input selection block
`ifndef GATE_SELECT_REGS_VH
`define GATE_SELECT_REGS_VH

`define ADDR_W 3
`define ADDR_GATE0_SEL 3'h0
`define ADDR_GATE1_SEL 3'h1
`define ADDR_POLARITY 3'h2
`define ADDR_DSEL1 3'h3
`define ADDR_DSEL2 3'h4
`define ADDR_DSEL3 3'h5
`define ADDR_DSEL4 3'h6
`define ADDR_GATE_STATUS 3'h7

`define BIT_IN4_TRUE 7
`define BIT_IN4_INV 6
`define BIT_IN3_TRUE 5
`define BIT_IN3_INV 4
`define BIT_IN2_TRUE 3
`define BIT_IN2_INV 2
`define BIT_IN1_TRUE 1
`define BIT_IN1_INV 0

`define BIT_GATE0_POL 0
`define BIT_GATE1_POL 1
`define DSEL_W 6
`define POL_W 2

`define RESET_SEL 8'h00
`define RESET_POL 2'h0
`define RESET_DSEL 6'h00
`define READ_ZERO 8'h00

`endif

/* File: hw/gate_input_select.v */
// gate 0 and gate 1 input term selection with data source muxes
//
// Summary of operation
// - gate0 bit7 admits true data input 4
// - gate0 bit6 admits inverted data input 4
// - gate0 bit5 admits true data input 3
// - gate0 bit4 admits inverted data input 3
// - gate0 bit3 admits true data input 2
// - gate0 bit2 admits inverted data input 2
// - gate0 bit1 admits true data input 1
// - gate0 bit0 admits inverted data input 1
// - gate1 bit7 admits true data input 4
// - gate1 bit6 admits inverted data input 4
// - gate1 bit5 admits true data input 3
// - gate1 bit4 admits inverted data input 3
// - gate1 bit3 admits true data input 2
// - gate1 bit2 admits inverted data input 2
// - gate1 bit1 admits true data input 1
// - gate1 bit0 admits inverted data input 1
// - selects read/write, kept over warm reset
// - polarity bit inverts each gate output
// - 6-bit field picks each data input
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`include "gate_select_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module gate_input_select #(
  parameter NUM_CAND = 64
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // power-on or brown-out reset, clears the otherwise unknown registers
  input wire por_rst,
  // register port
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_ff,
  // candidate input signals from outside the clock domain
  input wire [NUM_CAND-1:0] cand_in,
  // gate outputs after polarity
  output reg gate0_out_ff,
  output reg gate1_out_ff
);

  // ****************************************
  // input synchroniser
  // ****************************************
  reg [NUM_CAND-1:0] sync1_ff;
  reg [NUM_CAND-1:0] sync2_ff;
  reg [NUM_CAND-1:0] sync3_ff;
  reg [NUM_CAND-1:0] cand_ff;
  wire [NUM_CAND-1:0] nxt_cand;

  // a change counts once stages two and three agree
  assign nxt_cand = (sync2_ff & sync3_ff) | (cand_ff & (sync2_ff | sync3_ff));

  always @(posedge clk) begin
    sync1_ff <= cand_in;
    sync2_ff <= sync1_ff;
    sync3_ff <= sync2_ff;
    if (rst) begin
      cand_ff <= {NUM_CAND{1'b0}};
    end else begin
      cand_ff <= nxt_cand;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] gate0_term_select_ff;
  reg [7:0] gate1_term_select_ff;
  reg [`POL_W-1:0] polarity_ff;
  reg [`DSEL_W-1:0] dsel_ff [0:3];

  // only power-on reset touches them; warm reset leaves them unchanged
  always @(posedge clk) begin
    if (por_rst) begin
      gate0_term_select_ff <= `RESET_SEL;
      gate1_term_select_ff <= `RESET_SEL;
      polarity_ff <= `RESET_POL;
      dsel_ff[0] <= `RESET_DSEL;
      dsel_ff[1] <= `RESET_DSEL;
      dsel_ff[2] <= `RESET_DSEL;
      dsel_ff[3] <= `RESET_DSEL;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_GATE0_SEL: begin
          gate0_term_select_ff <= reg_wdata;
        end
        `ADDR_GATE1_SEL: begin
          gate1_term_select_ff <= reg_wdata;
        end
        `ADDR_POLARITY: begin
          polarity_ff <= reg_wdata[`POL_W-1:0];
        end
        `ADDR_DSEL1: begin
          dsel_ff[0] <= reg_wdata[`DSEL_W-1:0];
        end
        `ADDR_DSEL2: begin
          dsel_ff[1] <= reg_wdata[`DSEL_W-1:0];
        end
        `ADDR_DSEL3: begin
          dsel_ff[2] <= reg_wdata[`DSEL_W-1:0];
        end
        `ADDR_DSEL4: begin
          dsel_ff[3] <= reg_wdata[`DSEL_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // data input selection
  // ****************************************
  wire [3:0] data_sel;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_dsel
      // out-of-range index reads as zero
      assign data_sel[gi] = (dsel_ff[gi] < NUM_CAND) ?
                            cand_ff[dsel_ff[gi]] : 1'b0;
    end
  endgenerate

  wire selected_data_in1 = data_sel[0];
  wire selected_data_in2 = data_sel[1];
  wire selected_data_in3 = data_sel[2];
  wire selected_data_in4 = data_sel[3];

  // ****************************************
  // gating
  // ****************************************
  // term vector in select register bit order
  wire [7:0] terms = {selected_data_in4, ~selected_data_in4,
                      selected_data_in3, ~selected_data_in3,
                      selected_data_in2, ~selected_data_in2,
                      selected_data_in1, ~selected_data_in1};

  wire g0_in4_true_en = gate0_term_select_ff[`BIT_IN4_TRUE];
  wire g0_in4_inv_en = gate0_term_select_ff[`BIT_IN4_INV];
  wire g0_in3_true_en = gate0_term_select_ff[`BIT_IN3_TRUE];
  wire g0_in3_inv_en = gate0_term_select_ff[`BIT_IN3_INV];
  wire g0_in2_true_en = gate0_term_select_ff[`BIT_IN2_TRUE];
  wire g0_in2_inv_en = gate0_term_select_ff[`BIT_IN2_INV];
  wire g0_in1_true_en = gate0_term_select_ff[`BIT_IN1_TRUE];
  wire g0_in1_inv_en = gate0_term_select_ff[`BIT_IN1_INV];

  wire gate0_raw = (g0_in4_true_en & terms[`BIT_IN4_TRUE]) |
                   (g0_in4_inv_en & terms[`BIT_IN4_INV]) |
                   (g0_in3_true_en & terms[`BIT_IN3_TRUE]) |
                   (g0_in3_inv_en & terms[`BIT_IN3_INV]) |
                   (g0_in2_true_en & terms[`BIT_IN2_TRUE]) |
                   (g0_in2_inv_en & terms[`BIT_IN2_INV]) |
                   (g0_in1_true_en & terms[`BIT_IN1_TRUE]) |
                   (g0_in1_inv_en & terms[`BIT_IN1_INV]);

  wire g1_in4_true_en = gate1_term_select_ff[`BIT_IN4_TRUE];
  wire g1_in4_inv_en = gate1_term_select_ff[`BIT_IN4_INV];
  wire g1_in3_true_en = gate1_term_select_ff[`BIT_IN3_TRUE];
  wire g1_in3_inv_en = gate1_term_select_ff[`BIT_IN3_INV];
  wire g1_in2_true_en = gate1_term_select_ff[`BIT_IN2_TRUE];
  wire g1_in2_inv_en = gate1_term_select_ff[`BIT_IN2_INV];
  wire g1_in1_true_en = gate1_term_select_ff[`BIT_IN1_TRUE];
  wire g1_in1_inv_en = gate1_term_select_ff[`BIT_IN1_INV];

  wire gate1_raw = (g1_in4_true_en & terms[`BIT_IN4_TRUE]) |
                   (g1_in4_inv_en & terms[`BIT_IN4_INV]) |
                   (g1_in3_true_en & terms[`BIT_IN3_TRUE]) |
                   (g1_in3_inv_en & terms[`BIT_IN3_INV]) |
                   (g1_in2_true_en & terms[`BIT_IN2_TRUE]) |
                   (g1_in2_inv_en & terms[`BIT_IN2_INV]) |
                   (g1_in1_true_en & terms[`BIT_IN1_TRUE]) |
                   (g1_in1_inv_en & terms[`BIT_IN1_INV]);

  // empty selection gives an all-zero OR, so raw gate is zero
  wire gate0_invert = polarity_ff[`BIT_GATE0_POL];
  wire gate1_invert = polarity_ff[`BIT_GATE1_POL];
  wire nxt_gate0_out = gate0_raw ^ gate0_invert;
  wire nxt_gate1_out = gate1_raw ^ gate1_invert;

  always @(posedge clk) begin
    if (rst) begin
      gate0_out_ff <= 1'b0;
      gate1_out_ff <= 1'b0;
    end else begin
      gate0_out_ff <= nxt_gate0_out;
      gate1_out_ff <= nxt_gate1_out;
    end
  end

  // ****************************************
  // register read
  // ****************************************
  reg [7:0] nxt_rdata;
  always @* begin
    nxt_rdata = `READ_ZERO;
    case (reg_addr)
      `ADDR_GATE0_SEL: begin
        nxt_rdata = gate0_term_select_ff;
      end
      `ADDR_GATE1_SEL: begin
        nxt_rdata = gate1_term_select_ff;
      end
      `ADDR_POLARITY: begin
        nxt_rdata[`POL_W-1:0] = polarity_ff;
      end
      `ADDR_DSEL1: begin
        nxt_rdata[`DSEL_W-1:0] = dsel_ff[0];
      end
      `ADDR_DSEL2: begin
        nxt_rdata[`DSEL_W-1:0] = dsel_ff[1];
      end
      `ADDR_DSEL3: begin
        nxt_rdata[`DSEL_W-1:0] = dsel_ff[2];
      end
      `ADDR_DSEL4: begin
        nxt_rdata[`DSEL_W-1:0] = dsel_ff[3];
      end
      `ADDR_GATE_STATUS: begin
        nxt_rdata[`BIT_GATE0_POL] = gate0_out_ff;
        nxt_rdata[`BIT_GATE1_POL] = gate1_out_ff;
      end
      default: begin
        nxt_rdata = `READ_ZERO;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_ff <= `READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= `READ_ZERO;
    end
  end

endmodule

`default_nettype wire

/* File: tb/gate_input_select_props.sv */
// checker for the gate input selection block
`timescale 1ns/10ps
`default_nettype none
`include "gate_select_regs.vh"
module gate_sel_chk #(parameter NUM_CAND = 64) (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic por_rst,
  // register port
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  // gate path
  input wire logic [NUM_CAND-1:0] cand_in,
  input wire logic gate0_out_ff,
  input wire logic gate1_out_ff
);
  // ****
  // shadow of the programmed selects
  // ****
  logic [7:0] s0_ff, s1_ff;
  logic [1:0] p_ff;
  logic t0, t1;
  always_ff @(posedge clk) begin
    if (por_rst) begin
      s0_ff <= 8'h00;
      s1_ff <= 8'h00;
      p_ff <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_GATE0_SEL) s0_ff <= reg_wdata;
      if (reg_addr == `ADDR_GATE1_SEL) s1_ff <= reg_wdata;
      if (reg_addr == `ADDR_POLARITY) p_ff <= reg_wdata[1:0];
    end
  end
  // a true and inverted pair of one input makes the gate constant one
  assign t0 = |(s0_ff & (s0_ff << 1) & 8'haa);
  assign t1 = |(s1_ff & (s1_ff << 1) & 8'haa);
  default clocking @(posedge clk); endclocking
  default disable iff (rst || por_rst);
  sequence s_quiet;
    !$past(rst) && !$past(rst, 2) && !$past(rst, 3) && $stable(p_ff)
      && $stable(s0_ff) && $stable(s1_ff);
  endsequence
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata_ff == 8'h00)
    else $error("read data not zero outside a read");
  AST_RD_G0: assert property (reg_rd && reg_addr == `ADDR_GATE0_SEL
    |=> reg_rdata_ff == $past(s0_ff)) else $error("gate0 select readback");
  AST_RD_G1: assert property (reg_rd && reg_addr == `ADDR_GATE1_SEL
    |=> reg_rdata_ff == $past(s1_ff)) else $error("gate1 select readback");
  AST_ZERO_G0: assert property (s_quiet ##0 s0_ff == 8'h00
    |-> gate0_out_ff == p_ff[0]) else $error("empty gate0 not zero");
  AST_ZERO_G1: assert property (s_quiet ##0 s1_ff == 8'h00
    |-> gate1_out_ff == p_ff[1]) else $error("empty gate1 not zero");
  AST_TAUT_G0: assert property (s_quiet ##0 t0
    |-> gate0_out_ff == !p_ff[0]) else $error("gate0 pair not one");
  AST_TAUT_G1: assert property (s_quiet ##0 t1
    |-> gate1_out_ff == !p_ff[1]) else $error("gate1 pair not one");
  AST_RST_OUT: assert property (disable iff (por_rst) rst
    |=> !gate0_out_ff && !gate1_out_ff) else $error("outputs live in reset");
endmodule
bind gate_input_select gate_sel_chk #(.NUM_CAND(NUM_CAND)) i_chk (
  .clk(clk), .rst(rst), .por_rst(por_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .cand_in(cand_in),
  .gate0_out_ff(gate0_out_ff), .gate1_out_ff(gate1_out_ff));
`default_nettype wire

/* File: tb/test_gate_input_select.sv */
// self-checking bench for the gate input selection block
`timescale 1ns/10ps
`default_nettype none
`include "gate_select_regs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("Error at %0t: %h vs %h", $time, a, e); end end
module test_gate_input_select;
  logic clk = 1'b0, rst = 1'b1, por_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [63:0] cand_in = 64'h0;
  logic e;
  wire logic [7:0] reg_rdata_ff;
  wire logic gate0_out_ff, gate1_out_ff;
  int num_errors = 0, checks = 0;
  always #5 clk = ~clk;
  gate_input_select #(.NUM_CAND(64)) i_dut (.clk(clk), .rst(rst),
    .por_rst(por_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .cand_in(cand_in), .gate0_out_ff(gate0_out_ff),
    .gate1_out_ff(gate1_out_ff));
  // ****
  // bus tasks and verdict
  // ****
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata_ff, x)
  endtask
  task settle;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    por_rst <= 1'b0;
    rst <= 1'b0;
    rd(`ADDR_GATE0_SEL, 8'h00);
    wr(`ADDR_GATE0_SEL, 8'ha5);
    wr(`ADDR_GATE1_SEL, 8'h5a);
    wr(`ADDR_POLARITY, 8'hff);
    for (int i = 1; i < 5; i++) wr(3'(i + 2), 8'(i));
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`ADDR_GATE0_SEL, 8'ha5);
    rd(`ADDR_GATE1_SEL, 8'h5a);
    rd(`ADDR_POLARITY, 8'h03);
    $display("register test done");
    wr(`ADDR_POLARITY, 8'h00);
    // other candidates opposite, so a wrong source pick shows
    for (int b = 0; b < 8; b++) begin
      for (int v = 0; v < 2; v++) begin
        cand_in <= v[0] ? (64'h1 << (b / 2 + 1)) : ~(64'h1 << (b / 2 + 1));
        wr(`ADDR_GATE0_SEL, 8'(1 << b));
        wr(`ADDR_GATE1_SEL, 8'(1 << b));
        settle;
        e = b[0] ? v[0] : !v[0];
        `CHK(gate0_out_ff, e)
        `CHK(gate1_out_ff, e)
      end
    end
    $display("term test done");
    wr(`ADDR_GATE0_SEL, 8'h00);
    wr(`ADDR_GATE1_SEL, 8'h00);
    settle;
    `CHK({gate1_out_ff, gate0_out_ff}, 2'h0)
    wr(`ADDR_POLARITY, 8'h03);
    wr(`ADDR_GATE0_SEL, 8'h0c);
    settle;
    `CHK({gate1_out_ff, gate0_out_ff}, 2'h2)
    rd(`ADDR_GATE_STATUS, 8'h02);
    wr(`ADDR_GATE1_SEL, 8'hc0);
    settle;
    `CHK({gate1_out_ff, gate0_out_ff}, 2'h0)
    $display("polarity test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
